// *** logic/gp_ports.sv ***
// gpio ports a to d with apb register access
`timescale 1ns/10ps
module gp_ports (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [5:0]  first_pin_in,
   output logic      [5:0]  first_pin_out,
   output logic      [5:0]  first_pin_oe,
   input  wire logic [7:0]  second_pin_in,
   output logic      [7:0]  second_pin_out,
   output logic      [7:0]  second_pin_oe,
   output logic      [7:0]  second_pullup_en,
   input  wire logic [5:0]  third_pin_in,
   output logic      [5:0]  third_pin_out,
   output logic      [5:0]  third_pin_oe,
   input  wire logic [5:0]  third_periph_out_en,
   input  wire logic [5:0]  third_periph_in_force,
   input  wire logic [5:0]  third_periph_out,
   output logic      [5:0]  third_periph_in,
   input  wire logic [7:0]  fourth_pin_in,
   output logic      [7:0]  fourth_pin_out,
   output logic      [7:0]  fourth_pin_oe,
   output logic      [7:0]  fourth_segment_sel,
   output logic             timer_ext_clock_in,
   output logic      [4:0]  analog_pin_sel,
   output logic             vref_pin_sel,
   output logic             ext_interrupt_pin,
   output logic             prog_clock_in,
   output logic             prog_data_in,
   output logic             change_flag,
   output logic             wake_up
);
   typedef struct packed {
      // two-stage synchronisers, one pair per port
      logic [5:0]  a_s1;
      logic [5:0]  a_s2;
      logic [7:0]  b_s1;
      logic [7:0]  b_s2;
      logic [5:0]  c_s1;
      logic [5:0]  c_s2;
      logic [7:0]  d_s1;
      logic [7:0]  d_s2;
      // software-visible latches and controls
      logic [5:0]  a_lat;
      logic [5:0]  a_dir;
      logic [7:0]  b_lat;
      logic [7:0]  b_dir;
      logic [5:0]  c_lat;
      logic [5:0]  c_dir;
      logic [7:0]  d_lat;
      logic [7:0]  d_dir;
      logic [7:0]  option;
      logic [2:0]  acfg;
      logic [7:0]  seg_en;
      // change detection and power state
      logic [3:0]  snap;
      logic        flag;
      logic        sleep;
      logic        prog_mode;
      logic        wake;
      // bus answer
      logic [31:0] rdata;
      logic        ready;
      logic        err;
      // registered copies of every pin-side output
      logic [5:0]  a_out;
      logic [5:0]  a_oe;
      logic [7:0]  b_out;
      logic [7:0]  b_oe;
      logic [7:0]  b_pu;
      logic [5:0]  c_out;
      logic [5:0]  c_oe;
      logic [5:0]  c_pin;
      logic [7:0]  d_out;
      logic [7:0]  d_oe;
      logic [7:0]  dseg;
      logic [4:0]  asel;
      logic        vref;
      logic        t0ck;
      logic        eint;
      logic        pclk_in;
      logic        pdat_in;
   } gp_state_s;

   gp_state_s st_r, st_nxt;

   // analog mask per first-port pin; bit 4 is never analog
   function automatic logic [5:0] analog_mask(input logic [2:0] cfg);
      case (cfg)
         3'h0:    analog_mask = 6'h2f;
         3'h1:    analog_mask = 6'h2f;
         3'h2:    analog_mask = 6'h2f;
         3'h3:    analog_mask = 6'h2f;
         3'h4:    analog_mask = 6'h0b;
         3'h5:    analog_mask = 6'h0b;
         3'h6:    analog_mask = 6'h00;
         3'h7:    analog_mask = 6'h00;
         default: analog_mask = 6'h00;
      endcase
   endfunction

   // odd codes other than 7 turn pin 3 into the reference input
   function automatic logic vref_sel(input logic [2:0] cfg);
      vref_sel = cfg[0] & (cfg != 3'h7);
   endfunction

   // paddr is a byte address; a misaligned offset never matches
   function automatic logic is_reg(input logic [11:0] a, input logic [8:0] idx);
      is_reg = (a[1:0] == 2'h0) && (a[11:2] == {1'b0, idx});
   endfunction

   // one enable bit owns pins 4:0, another owns pins 7:5
   function automatic logic [7:0] seg_spread(input logic [7:0] en);
      seg_spread = {{3{en[gp_pkg::POS_SEG_HIGH]}}, {5{en[gp_pkg::POS_SEG_LOW]}}};
   endfunction

   logic       setup_wr;
   logic       setup_rd;
   logic [5:0] amask;
   logic [5:0] a_dig;
   logic [3:0] mism;
   logic [5:0] c_dir_eff;
   logic [7:0] d_seg;

   // everything is decoded in the setup cycle; the access phase only reports
   assign setup_wr = psel & ~penable & pwrite;
   assign setup_rd = psel & ~penable & ~pwrite;

   always_comb begin
      st_nxt = st_r;
      st_nxt.ready = 1'b0;
      st_nxt.err = 1'b0;
      // two-stage synchronisers; stage one only feeds stage two
      st_nxt.a_s1 = first_pin_in;
      st_nxt.a_s2 = st_r.a_s1;
      st_nxt.b_s1 = second_pin_in;
      st_nxt.b_s2 = st_r.b_s1;
      st_nxt.c_s1 = third_pin_in;
      st_nxt.c_s2 = st_r.c_s1;
      st_nxt.d_s1 = fourth_pin_in;
      st_nxt.d_s2 = st_r.d_s1;

      amask = analog_mask(st_r.acfg);
      a_dig = ~amask;
      // mismatch on input pins only, upper nibble
      mism = (st_r.b_s2[7:4] ^ st_r.snap) & st_r.b_dir[7:4];
      if (|mism) begin
         st_nxt.flag = 1'b1;
         if (st_r.sleep) begin
            st_nxt.sleep = 1'b0;
            st_nxt.wake = 1'b1;
         end
      end

      // answer with zero wait states: access phase always ready
      if (setup_wr | setup_rd) begin
         st_nxt.ready = 1'b1;
         st_nxt.rdata = 32'h0000_0000;
         st_nxt.err = 1'b1;
         if (is_reg(paddr, gp_pkg::IDX_FIRST_DATA)) begin
            st_nxt.err = 1'b0;
            st_nxt.rdata[5:0] = st_r.a_s2 & a_dig;
            // a write loads the latch from pwdata alone; a read returns the sampled pins, analog pins as zero
            if (pwrite)
               st_nxt.a_lat = pwdata[5:0];
         end

         if (is_reg(paddr, gp_pkg::IDX_SECOND_DATA)) begin
            st_nxt.err = 1'b0;
            st_nxt.rdata[7:0] = st_r.b_s2;
            st_nxt.snap = st_r.b_s2[7:4];
            if (pwrite)
               st_nxt.b_lat = pwdata[7:0];
         end

         if (is_reg(paddr, gp_pkg::IDX_THIRD_DATA)) begin
            st_nxt.err = 1'b0;
            st_nxt.rdata[5:0] = st_r.c_s2;
            if (pwrite)
               st_nxt.c_lat = pwdata[5:0];
         end

         if (is_reg(paddr, gp_pkg::IDX_FOURTH_DATA)) begin
            st_nxt.err = 1'b0;
            st_nxt.rdata[7:0] = st_r.d_s2;
            if (pwrite)
               st_nxt.d_lat = pwdata[7:0];
         end

         if (is_reg(paddr, gp_pkg::IDX_INTR_CTRL)) begin
            st_nxt.err = 1'b0;
            st_nxt.rdata[gp_pkg::POS_CHANGE_FLAG] = st_r.flag;
            // software clear loses to a live mismatch
            if (pwrite && !pwdata[gp_pkg::POS_CHANGE_FLAG] && !(|mism))
               st_nxt.flag = 1'b0;
         end

         if (is_reg(paddr, gp_pkg::IDX_OPTION)) begin
            st_nxt.err = 1'b0;
            st_nxt.rdata[7:0] = st_r.option;
            if (pwrite)
               st_nxt.option = pwdata[7:0];
         end

         if (is_reg(paddr, gp_pkg::IDX_FIRST_DIR)) begin
            st_nxt.err = 1'b0;
            st_nxt.rdata[5:0] = st_r.a_dir;
            if (pwrite)
               st_nxt.a_dir = pwdata[5:0];
         end

         if (is_reg(paddr, gp_pkg::IDX_SECOND_DIR)) begin
            st_nxt.err = 1'b0;
            st_nxt.rdata[7:0] = st_r.b_dir;
            if (pwrite)
               st_nxt.b_dir = pwdata[7:0];
         end

         if (is_reg(paddr, gp_pkg::IDX_THIRD_DIR)) begin
            st_nxt.err = 1'b0;
            st_nxt.rdata[5:0] = st_r.c_dir;
            if (pwrite)
               st_nxt.c_dir = pwdata[5:0];
         end

         if (is_reg(paddr, gp_pkg::IDX_FOURTH_DIR)) begin
            st_nxt.err = 1'b0;
            st_nxt.rdata[7:0] = st_r.d_dir;
            if (pwrite)
               st_nxt.d_dir = pwdata[7:0];
         end

         if (is_reg(paddr, gp_pkg::IDX_ANALOG_CFG)) begin
            st_nxt.err = 1'b0;
            st_nxt.rdata[2:0] = st_r.acfg;
            if (pwrite)
               st_nxt.acfg = pwdata[2:0];
         end

         if (is_reg(paddr, gp_pkg::IDX_SEG_ENABLE)) begin
            st_nxt.err = 1'b0;
            st_nxt.rdata[7:0] = st_r.seg_en;
            if (pwrite)
               st_nxt.seg_en = pwdata[7:0];
         end

         if (is_reg(paddr, gp_pkg::IDX_CTRL_STATUS)) begin
            st_nxt.err = 1'b0;
            st_nxt.rdata[gp_pkg::POS_SLEEP] = st_r.sleep;
            st_nxt.rdata[gp_pkg::POS_WAKE] = st_r.wake;
            st_nxt.rdata[gp_pkg::POS_PROG_MODE] = st_r.prog_mode;
            st_nxt.rdata[gp_pkg::POS_PIN_STATE] = |mism;
            if (pwrite) begin
               st_nxt.sleep = pwdata[gp_pkg::POS_SLEEP] & ~(|mism);
               st_nxt.prog_mode = pwdata[gp_pkg::POS_PROG_MODE];
               if (pwdata[gp_pkg::POS_WAKE] && !(|mism && st_r.sleep))
                  st_nxt.wake = 1'b0;
            end
         end
         // a refused write still must not alter anything; error only on the bus
         if (st_nxt.err)
            st_nxt.rdata = 32'h0000_0000;
      end

      // first port drivers; bit 4 open drain pulls low only
      st_nxt.a_out = st_r.a_lat;
      st_nxt.a_oe = ~st_r.a_dir;
      st_nxt.a_out[gp_pkg::POS_OPEN_DRAIN] = 1'b0;
      st_nxt.a_oe[gp_pkg::POS_OPEN_DRAIN] = ~st_r.a_dir[gp_pkg::POS_OPEN_DRAIN] &
                                             ~st_r.a_lat[gp_pkg::POS_OPEN_DRAIN];
      st_nxt.t0ck = st_r.a_s2[gp_pkg::POS_OPEN_DRAIN];

      // second port
      st_nxt.b_out = st_r.b_lat;
      st_nxt.b_oe = ~st_r.b_dir;
      st_nxt.b_pu = st_r.option[gp_pkg::POS_PULLUP_DIS_N] ? 8'h00 : st_r.b_dir;
      // schmitt buffers are in the pad; core sees the synchronised level
      st_nxt.eint = st_r.b_s2[gp_pkg::POS_EXT_INT];
      st_nxt.pclk_in = st_r.prog_mode & st_r.b_s2[gp_pkg::POS_PROG_CLK];
      st_nxt.pdat_in = st_r.prog_mode & st_r.b_s2[gp_pkg::POS_PROG_DAT];

      // third port; peripheral overrides win while enabled
      c_dir_eff = (st_r.c_dir | third_periph_in_force) & ~third_periph_out_en;
      st_nxt.c_out = (third_periph_out & third_periph_out_en) |
                     (st_r.c_lat & ~third_periph_out_en);
      st_nxt.c_oe = ~c_dir_eff;
      st_nxt.c_pin = st_r.c_s2;

      // fourth port; bits 5..7 never drive, segment enable overrides direction
      d_seg = seg_spread(st_r.seg_en);
      st_nxt.d_out = st_r.d_lat;
      st_nxt.d_oe = ~st_r.d_dir & ~d_seg & 8'h1f;
      // owner map and enables come from one register, so they never disagree
      st_nxt.dseg = d_seg;

      // analog routing registered so the converter side sees a clean level
      st_nxt.asel = {amask[5], amask[3:0]};
      st_nxt.vref = vref_sel(st_r.acfg);
   end

   // only one reset exists, so every latch starts from a known value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
         st_r.a_lat <= gp_pkg::RST_FIRST_DATA[5:0];
         st_r.a_dir <= gp_pkg::RST_DIR6;
         st_r.b_dir <= gp_pkg::RST_DIR8;
         st_r.c_dir <= gp_pkg::RST_DIR6;
         st_r.d_dir <= gp_pkg::RST_DIR8;
         st_r.d_lat <= gp_pkg::RST_FOURTH_DATA;
         st_r.option <= gp_pkg::RST_OPTION;
         st_r.acfg <= gp_pkg::RST_ANALOG_CFG;
         st_r.seg_en <= gp_pkg::RST_SEG_ENABLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // every output below is a bare register field
   assign prdata             = st_r.rdata;
   assign pready             = st_r.ready;
   assign pslverr            = st_r.err;
   assign first_pin_out      = st_r.a_out;
   assign first_pin_oe       = st_r.a_oe;
   assign second_pin_out     = st_r.b_out;
   assign second_pin_oe      = st_r.b_oe;
   assign second_pullup_en   = st_r.b_pu;
   assign third_pin_out      = st_r.c_out;
   assign third_pin_oe       = st_r.c_oe;
   assign third_periph_in    = st_r.c_pin;
   assign fourth_pin_out     = st_r.d_out;
   assign fourth_pin_oe      = st_r.d_oe;
   assign fourth_segment_sel = st_r.dseg;
   assign timer_ext_clock_in = st_r.t0ck;
   assign analog_pin_sel     = st_r.asel;
   assign vref_pin_sel       = st_r.vref;
   assign ext_interrupt_pin  = st_r.eint;
   assign prog_clock_in      = st_r.pclk_in;
   assign prog_data_in       = st_r.pdat_in;
   assign change_flag        = st_r.flag;
   assign wake_up            = st_r.wake;
endmodule

// *** logic/gp_pkg.sv ***
// constants for the four-port general-purpose i/o block
package gp_pkg;
   // register indices as printed; byte address is four times the index
   localparam logic [8:0] IDX_FIRST_DATA   = 9'h005;
   localparam logic [8:0] IDX_SECOND_DATA  = 9'h006;
   localparam logic [8:0] IDX_THIRD_DATA   = 9'h007;
   localparam logic [8:0] IDX_FOURTH_DATA  = 9'h008;
   localparam logic [8:0] IDX_INTR_CTRL    = 9'h00b;
   localparam logic [8:0] IDX_OPTION       = 9'h081;
   localparam logic [8:0] IDX_FIRST_DIR    = 9'h085;
   localparam logic [8:0] IDX_SECOND_DIR   = 9'h086;
   localparam logic [8:0] IDX_THIRD_DIR    = 9'h087;
   localparam logic [8:0] IDX_FOURTH_DIR   = 9'h088;
   localparam logic [8:0] IDX_ANALOG_CFG   = 9'h09f;
   localparam logic [8:0] IDX_SEG_ENABLE   = 9'h10d;
   localparam logic [8:0] IDX_CTRL_STATUS  = 9'h110;
   // reset values
   localparam logic [7:0] RST_OPTION       = 8'hff;
   localparam logic [5:0] RST_DIR6         = 6'h3f;
   localparam logic [7:0] RST_DIR8         = 8'hff;
   localparam logic [2:0] RST_ANALOG_CFG   = 3'h0;
   localparam logic [7:0] RST_SEG_ENABLE   = 8'hff;
   localparam logic [7:0] RST_FOURTH_DATA  = 8'h00;
   localparam logic [7:0] RST_FIRST_DATA   = 8'h00;
   // field positions
   localparam int POS_PULLUP_DIS_N = 7;
   localparam int POS_CHANGE_FLAG  = 0;
   localparam int POS_OPEN_DRAIN   = 4;
   localparam int POS_EXT_INT      = 0;
   localparam int POS_PROG_CLK     = 6;
   localparam int POS_PROG_DAT     = 7;
   localparam int POS_SLEEP        = 0;
   localparam int POS_WAKE         = 1;
   localparam int POS_PROG_MODE    = 2;
   localparam int POS_PIN_STATE    = 3;
   // segment enable bits that own fourth-port pins
   localparam int POS_SEG_LOW      = 0;
   localparam int POS_SEG_HIGH     = 7;
endpackage

// *** sim/gp_ports_properties.sv ***
// concurrent checks on the ports of the gpio block
`timescale 1ns/10ps
module gp_ports_properties (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [5:0]  first_pin_out,
   input wire logic [5:0]  first_pin_oe,
   input wire logic [7:0]  second_pin_oe,
   input wire logic [7:0]  second_pullup_en,
   input wire logic [7:0]  fourth_pin_oe,
   input wire logic [7:0]  fourth_segment_sel,
   input wire logic        change_flag
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_flag_write;
      s_setup and (pwrite && paddr == 12'h02c);
   endsequence
   property p_answer;
      s_setup |=> pready;
   endproperty
   property p_one_pulse;
      pready |=> !pready;
   endproperty
   property p_in_access;
      pready |-> psel && penable;
   endproperty
   property p_err_zero;
      pslverr |-> pready && prdata == 32'h0;
   endproperty
   property p_err_map;
      s_setup and paddr == 12'h3fc |=> pslverr;
   endproperty
   property p_pullup_out;
      (second_pullup_en & second_pin_oe) == 8'h00;
   endproperty
   property p_open_drain;
      first_pin_oe[4] |-> !first_pin_out[4];
   endproperty
   property p_input_only;
      fourth_pin_oe[7:5] == 3'h0;
   endproperty
   // the past term keeps the check off the first edge that sees fourth_segment_sel[0] high
   property p_seg_owns;
      fourth_segment_sel[0] && $past(fourth_segment_sel[0]) |-> fourth_pin_oe[4:0] == 5'h00;
   endproperty
   property p_flag_holds;
      change_flag && !(psel && !penable && pwrite && paddr == 12'h02c) |=> change_flag;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer after setup");
   a_one_pulse: assert property (p_one_pulse) else $error("pready longer than one cycle");
   a_in_access: assert property (p_in_access) else $error("pready outside access phase");
   a_err_zero: assert property (p_err_zero) else $error("error answer with data");
   a_err_map: assert property (p_err_map) else $error("unmapped access not refused");
   a_pullup_out: assert property (p_pullup_out) else $error("pullup on driven pin");
   a_open_drain: assert property (p_open_drain) else $error("open drain pin driven high");
   a_input_only: assert property (p_input_only) else $error("input only pin driven");
   a_seg_owns: assert property (p_seg_owns) else $error("segment pin driven");
   a_flag_holds: assert property (p_flag_holds) else $error("change flag dropped");
endmodule
bind gp_ports gp_ports_properties u_gp_ports_properties (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .prdata, .pready, .pslverr, .first_pin_out, .first_pin_oe, .second_pin_oe, .second_pullup_en,
   .fourth_pin_oe, .fourth_segment_sel, .change_flag);

// *** sim/gp_pad.sv ***
// board side of one port: pads, external drivers and floating lines
`timescale 1ns/10ps
module gp_pad #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic [W-1:0] out,
   input  wire logic [W-1:0] oe,
   input  wire logic [W-1:0] pu,
   input  wire logic [W-1:0] ext_v,
   input  wire logic [W-1:0] ext_en,
   output logic      [W-1:0] lvl
);
   // a floating line toggles so a stale value never reads as valid
   logic [W-1:0] fl = '0;
   always @(posedge clk)
      fl <= ~fl;
   assign lvl = (oe & out) | (~oe & ext_en & ext_v) | (~oe & ~ext_en & (pu | fl));
endmodule

// *** sim/test_gp_ports.sv ***
// self-checking bench for the four-port gpio block
`timescale 1ns/10ps
module test_gp_ports;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [7:0]  second_pin_in, second_pin_out, second_pin_oe, second_pullup_en, v2, e2;
   logic [7:0]  fourth_pin_in, fourth_pin_out, fourth_pin_oe, fourth_segment_sel, v4, e4;
   logic [5:0]  first_pin_in, first_pin_out, first_pin_oe, v1, e1, v3, e3;
   logic [5:0]  third_pin_in, third_pin_out, third_pin_oe, third_periph_in;
   logic [5:0]  third_periph_out_en, third_periph_in_force, third_periph_out;
   logic [4:0]  analog_pin_sel;
   logic        timer_ext_clock_in, vref_pin_sel, ext_interrupt_pin, prog_clock_in, prog_data_in;
   logic        change_flag, wake_up;
   int          error_cnt, cmp_count, cyc;
   gp_ports u_gp_ports (.*);
   gp_pad #(.W(6)) u_gp_pad_1 (.clk(pclk), .out(first_pin_out), .oe(first_pin_oe), .pu(6'h00),
      .ext_v(v1), .ext_en(e1), .lvl(first_pin_in));
   gp_pad u_gp_pad_2 (.clk(pclk), .out(second_pin_out), .oe(second_pin_oe), .pu(second_pullup_en),
      .ext_v(v2), .ext_en(e2), .lvl(second_pin_in));
   gp_pad #(.W(6)) u_gp_pad_3 (.clk(pclk), .out(third_pin_out), .oe(third_pin_oe), .pu(6'h00),
      .ext_v(v3), .ext_en(e3), .lvl(third_pin_in));
   gp_pad u_gp_pad_4 (.clk(pclk), .out(fourth_pin_out), .oe(fourth_pin_oe), .pu(8'h00),
      .ext_v(v4), .ext_en(e4), .lvl(fourth_pin_in));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         give_verdict();
      end
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      cmp_count++;
      if (s !== x) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", n, x, s);
      end
   endtask
   // the request stands until pready is sampled high; one idle edge follows
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
      bus(1'b0, a, 32'h0);
      chk(n, q, x);
   endtask
   task automatic t_reset;
      rd(12'h204, 32'hff, "option");
      rd(12'h214, 32'h3f, "first_dir");
      rd(12'h218, 32'hff, "second_dir");
      rd(12'h21c, 32'h3f, "third_dir");
      rd(12'h220, 32'hff, "fourth_dir");
      rd(12'h27c, 32'h00, "analog_cfg");
      rd(12'h434, 32'hff, "seg_enable");
      rd(12'h020, 32'h00, "fourth_data");
      rd(12'h014, 32'h10, "first_data");
      chk("pullups", second_pullup_en, 8'h00);
      bus(1'b0, 12'h3fc, 32'h0);
      chk("slverr", e, 1'b1);
   endtask
   task automatic t_first;
      for (int c = 0; c < 8; c++) begin
         wr(12'h27c, c);
         chk("analog_sel", analog_pin_sel, c < 4 ? 5'h1f : c < 6 ? 5'h0b : 5'h00);
         chk("vref_sel", vref_pin_sel, c % 2 == 1 && c < 6);
      end
      wr(12'h014, 8'h00);
      wr(12'h214, 8'h00);
      chk("first_oe", first_pin_oe, 6'h3f);
      chk("first_out", first_pin_out, 6'h00);
      wr(12'h014, 8'hff);
      chk("first_oe", first_pin_oe, 6'h2f);
      chk("first_out", first_pin_out & 6'h2f, 6'h2f);
      wr(12'h214, 8'hff);
      rd(12'h214, 32'h3f, "first_dir");
      v1 <= 6'h15;
      repeat (4) @(posedge pclk);
      rd(12'h014, 32'h15, "first_data");
      chk("timer_clk", timer_ext_clock_in, 1'b1);
   endtask
   task automatic t_second;
      wr(12'h204, 8'h7f);
      chk("pullups", second_pullup_en, 8'hff);
      wr(12'h018, 8'ha5);
      wr(12'h218, 8'h0f);
      chk("pullups", second_pullup_en, 8'h0f);
      chk("second_oe", second_pin_oe, 8'hf0);
      chk("second_out", second_pin_out & 8'hf0, 8'ha0);
      wr(12'h218, 8'hff);
      repeat (4) @(posedge pclk);
      rd(12'h018, 32'h00, "second_data");
      wr(12'h02c, 8'h00);
      v2 <= 8'h08;
      repeat (6) @(posedge pclk);
      chk("flag", change_flag, 1'b0);
      v2 <= 8'h28;
      repeat (6) @(posedge pclk);
      chk("flag", change_flag, 1'b1);
      wr(12'h02c, 8'h00);
      chk("flag", change_flag, 1'b1);
      rd(12'h018, 32'h28, "second_data");
      wr(12'h02c, 8'h00);
      chk("flag", change_flag, 1'b0);
      wr(12'h218, 8'h7f);
      repeat (6) @(posedge pclk);
      chk("flag", change_flag, 1'b0);
      wr(12'h218, 8'hff);
      repeat (6) @(posedge pclk);
      rd(12'h018, 32'h28, "second_data");
      wr(12'h02c, 8'h00);
      wr(12'h440, 8'h01);
      v2 <= 8'h38;
      repeat (6) @(posedge pclk);
      chk("wake", wake_up, 1'b1);
      v2 <= 8'hc1;
      wr(12'h440, 8'h04);
      repeat (4) @(posedge pclk);
      chk("ext_int", ext_interrupt_pin, 1'b1);
      chk("prog_clk", prog_clock_in, 1'b1);
      chk("prog_dat", prog_data_in, 1'b1);
   endtask
   task automatic t_third;
      wr(12'h01c, 8'h15);
      wr(12'h21c, 8'h00);
      chk("third_oe", third_pin_oe, 6'h3f);
      chk("third_out", third_pin_out, 6'h15);
      third_periph_in_force <= 6'h01;
      third_periph_out_en <= 6'h02;
      third_periph_out <= 6'h02;
      repeat (2) @(posedge pclk);
      chk("third_oe", third_pin_oe, 6'h3e);
      chk("third_out", third_pin_out & 6'h3e, 6'h16);
      wr(12'h21c, 8'hff);
      rd(12'h21c, 32'h3f, "third_dir");
      repeat (2) @(posedge pclk);
      chk("third_in", third_periph_in, 6'h02);
   endtask
   task automatic t_fourth;
      wr(12'h020, 8'h1f);
      wr(12'h220, 8'h00);
      chk("fourth_oe", fourth_pin_oe, 8'h00);
      wr(12'h434, 8'h7e);
      chk("fourth_oe", fourth_pin_oe, 8'h1f);
      chk("fourth_out", fourth_pin_out & 8'h1f, 8'h1f);
      chk("seg_sel", fourth_segment_sel, 8'h00);
   endtask
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      {v1, e1, v3, e3} = {6'h3f, 6'h3f, 6'h00, 6'h3f};
      {v2, e2, v4, e4} = {8'h00, 8'hff, 8'h00, 8'hff};
      {third_periph_out_en, third_periph_in_force, third_periph_out} = 18'h0;
      {error_cnt, cmp_count, cyc} = {32'd0, 32'd0, 32'd0};
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_first();
      t_second();
      t_third();
      t_fourth();
      give_verdict();
   end
endmodule
